// >>> hw/pack_protector_pkg.sv
// Constants and carrier types for the pack protector pin control block
package pack_protector_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, 32-bit words)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_HOSTFET = 8'h04;
  localparam logic [7:0] REG_MASK    = 8'h08;
  localparam logic [7:0] REG_PINCFG  = 8'h0C;
  localparam logic [7:0] REG_FUSE    = 8'h10;
  localparam logic [7:0] REG_OWINT   = 8'h14;
  localparam logic [7:0] REG_STATUS  = 8'h18;
  localparam logic [7:0] REG_FLAGS   = 8'h1C;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_STANDALONE = 2'h0;
  localparam logic [1:0] OP_HOST_AUTO  = 2'h1;
  localparam logic [1:0] OP_MANUAL     = 2'h2;

  localparam logic [1:0] ALR_OD_LOW   = 2'h0;
  localparam logic [1:0] ALR_HIGH     = 2'h1;
  localparam logic [1:0] ALR_INV_LOW  = 2'h2;

  // Switch index order: charge, precharge, discharge, predischarge
  localparam int SW_CHG  = 0;
  localparam int SW_PRECHARGE_SWITCH = 1;
  localparam int SW_DSG  = 2;
  localparam int SW_PREDISCHARGE_SWITCH = 3;

  // Sticky flag positions
  localparam int FL_PROT  = 0;
  localparam int FL_PF    = 1;
  localparam int FL_SEC   = 2;
  localparam int FL_OW    = 3;

  typedef struct packed {
    logic [1:0] op_mode;
    logic       link_sw;
    logic       combined;
    logic       chg_pin_en;
    logic       dsg_pin_en;
  } ctrl_t;

  typedef struct packed {
    logic [1:0] alert_style;
    logic [2:0] pull_up;
    logic [2:0] pull_en;
    logic [2:0] ext_sup;
    logic [2:0] gpo_val;
    logic [2:0] gpo_en;
  } pincfg_t;

  typedef struct packed {
    logic        blow_en;
    logic        sense_en;
    logic        use_pack;
    logic [15:0] thresh;
  } fusecfg_t;

  localparam ctrl_t CTRL_RST = 6'h03;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned I2C_MAX_KHZ  = 400;
  localparam int unsigned HOLD_TIME_S  = 1;
  localparam int unsigned MEAS_TIME_MS = 3;
  localparam int unsigned MS_CYCLES    = CLK_HZ / 1000;
  localparam int unsigned HOLD_CYCLES  = HOLD_TIME_S * CLK_HZ;
  localparam int unsigned MEAS_CYCLES  = MEAS_TIME_MS * MS_CYCLES;

endpackage : pack_protector_pkg

// >>> hw/pack_protector_pin_control.sv
// Pin control logic: switch-off pins, reset/shutdown pin, alarm, fuse, open wire
`timescale 1ns/1ps
`default_nettype none

module pack_protector_pin_control
  import pack_protector_pkg::*;
#(
  parameter int unsigned CELLS     = 5,
  parameter int unsigned HOLD_CYC  = HOLD_CYCLES,
  parameter int unsigned MS_CYC    = MS_CYCLES,
  parameter int unsigned MEAS_CYC  = MEAS_CYCLES
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  input  wire logic             rst_shut_i,
  input  wire logic [2:0]       mf_in_i,
  output logic      [2:0]       mf_out_o,
  output logic      [2:0]       mf_oe_o,
  output logic      [2:0]       mf_ext_supply_o,
  output logic      [2:0]       mf_pulldown_o,
  output logic      [2:0]       mf_pullup_o,
  input  wire logic             link_tx_low_i,
  input  wire logic             fuse_i,
  output logic                  fuse_o,
  output logic                  fuse_oe_o,
  input  wire logic [3:0]       prot_block_i,
  input  wire logic             pf_event_i,
  input  wire logic [7:0]       alarm_event_i,
  input  wire logic [15:0]      stack_mv_i,
  input  wire logic [15:0]      pack_mv_i,
  input  wire logic [CELLS-1:0] cell_low_i,
  input  wire logic [CELLS-1:0] cell_pf_i,
  output logic      [3:0]       fet_en_o,
  output logic                  link_sel_o,
  output logic                  comm_rst_o,
  output logic                  osc_en_o,
  output logic                  core_reg_en_o,
  output logic                  prereg_en_o,
  output logic                  ext_reg_en_o,
  output logic                  ow_sink_o,
  output logic      [CELLS-1:0] ow_fault_o,
  output logic                  pf_o
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (CELLS < 2 || CELLS > 8) begin : g_bad_cells
    $error("CELLS must be 2..8");
  end
  if (HOLD_CYC < 1 || MS_CYC < 1 || MEAS_CYC < 1) begin : g_bad_cyc
    $error("cycle counts must be at least one");
  end

  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int MW = $clog2(MS_CYC + 1);
  localparam int TW = $clog2(MEAS_CYC + 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             rs1;
    logic             rs2;
    logic [2:0]       in1;
    logic [2:0]       in2;
    logic             fs1;
    logic             fs2;
    ctrl_t            ctrl;
    logic [3:0]       host_off;
    logic [15:0]      mask;
    pincfg_t          pcfg;
    fusecfg_t         fcfg;
    logic [15:0]      ow_int;
    logic [7:0]       flags;
    logic             pf;
    logic             fuse_drv;
    logic             shut;
    logic             pwr_on;
    logic [HW-1:0]    hold;
    logic [MW-1:0]    ms;
    logic [15:0]      ow_cnt;
    logic [TW-1:0]    meas;
    logic             ow_sink;
    logic [CELLS-1:0] ow_fault;
    logic [3:0]       fet_en;
    logic [2:0]       mf_out;
    logic [2:0]       mf_oe;
    logic [2:0]       mf_ext;
    logic [2:0]       mf_pd;
    logic [2:0]       mf_pu;
    logic [31:0]      rdata;
    logic             comm_rst;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic             manual;
  logic             chg_off;
  logic             dsg_off;
  logic [3:0]       pin_blk;
  logic [3:0]       prot_blk;
  logic [15:0]      fuse_v;
  logic             fuse_ok;
  logic             alarm;
  logic [CELLS-1:0] spread;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;
    st_d.rs1 = rst_shut_i;
    st_d.rs2 = st_q.rs1;
    st_d.in1 = mf_in_i;
    st_d.in2 = st_q.in1;
    st_d.fs1 = fuse_i;
    st_d.fs2 = st_q.fs1;

    manual  = (st_q.ctrl.op_mode == OP_MANUAL);
    // Charge pin freed for other use under the combined option
    chg_off = st_q.ctrl.chg_pin_en && !st_q.ctrl.combined
              && !st_q.pcfg.gpo_en[1] && st_q.in2[1];
    dsg_off = st_q.ctrl.dsg_pin_en && !st_q.pcfg.gpo_en[2]
              && st_q.in2[2];
    pin_blk[SW_CHG]  = chg_off || (st_q.ctrl.combined && dsg_off);
    pin_blk[SW_PRECHARGE_SWITCH] = chg_off || (st_q.ctrl.combined && dsg_off);
    pin_blk[SW_DSG]  = dsg_off;
    pin_blk[SW_PREDISCHARGE_SWITCH] = dsg_off;
    // Manual mode never blocks on its own
    prot_blk = manual ? 4'h0 : (prot_block_i | {4{st_q.pf}});

    fuse_v  = st_q.fcfg.use_pack ? pack_mv_i : stack_mv_i;
    fuse_ok = st_q.fcfg.blow_en && st_q.pf
              && (fuse_v > st_q.fcfg.thresh);
    alarm   = |({alarm_event_i, st_q.flags} & st_q.mask);
    spread  = cell_low_i | {cell_low_i[CELLS-2:0], 1'b0};

    // --------------------------------------------------------------
    // Register access; ignored while the reset pin is high
    // --------------------------------------------------------------
    if (reg_wr_i && !st_q.rs2) begin
      case (reg_addr_i)
        REG_CTRL:    st_d.ctrl     = reg_wdata_i[5:0];
        REG_HOSTFET: st_d.host_off = reg_wdata_i[3:0];
        REG_MASK:    st_d.mask     = reg_wdata_i[15:0];
        REG_PINCFG:  st_d.pcfg     = reg_wdata_i[16:0];
        REG_FUSE:    st_d.fcfg     = reg_wdata_i[18:0];
        REG_OWINT:   st_d.ow_int   = reg_wdata_i[15:0];
        REG_FLAGS:   st_d.flags    = st_q.flags & ~reg_wdata_i[7:0];
        default:     st_d.rdata    = '0;
      endcase
    end
    if (reg_rd_i && !st_q.rs2) begin
      case (reg_addr_i)
        REG_CTRL:    st_d.rdata[5:0]  = st_q.ctrl;
        REG_HOSTFET: st_d.rdata[3:0]  = st_q.host_off;
        REG_MASK:    st_d.rdata[15:0] = st_q.mask;
        REG_PINCFG:  st_d.rdata[16:0] = st_q.pcfg;
        REG_FUSE:    st_d.rdata[18:0] = st_q.fcfg;
        REG_OWINT:   st_d.rdata[15:0] = st_q.ow_int;
        REG_FLAGS:   st_d.rdata[7:0]  = st_q.flags;
        REG_STATUS: begin
          st_d.rdata[3:0]       = st_q.fet_en;
          st_d.rdata[4]         = st_q.pf;
          st_d.rdata[5]         = st_q.fuse_drv;
          st_d.rdata[6]         = st_q.rs2;
          st_d.rdata[7]         = st_q.ow_sink;
          st_d.rdata[8 +: CELLS] = st_q.ow_fault;
          st_d.rdata[18:16]     = st_q.in2;
        end
        default:     st_d.rdata   = '0;
      endcase
    end

    // --------------------------------------------------------------
    // Reset/shutdown pin
    // --------------------------------------------------------------
    // Switch, host-off, failure and fuse state survive this reset
    if (st_q.rs2) begin
      st_d.comm_rst = 1'b1;
      st_d.ctrl     = CTRL_RST;
      st_d.mask     = '0;
      st_d.pcfg     = '0;
      st_d.ow_int   = '0;
      st_d.flags    = '0;
      if (st_q.hold != HW'(HOLD_CYC - 1)) begin
        st_d.hold = st_q.hold + HW'(1);
      end else begin
        st_d.shut = 1'b1;
      end
    end else begin
      st_d.comm_rst = 1'b0;
      st_d.hold     = '0;
    end
    st_d.pwr_on = !st_d.shut;

    // --------------------------------------------------------------
    // Open-wire check
    // --------------------------------------------------------------
    if (st_q.ow_sink) begin
      if (st_q.meas == TW'(MEAS_CYC - 1)) begin
        st_d.ow_sink  = 1'b0;
        st_d.meas     = '0;
        st_d.ow_fault = spread;
        if (|spread) st_d.flags[FL_OW] = 1'b1;
        if (|cell_pf_i) st_d.pf = 1'b1;
      end else begin
        st_d.meas = st_q.meas + TW'(1);
      end
    end
    // Interval runs start to start; a start inside a sink is skipped
    if (st_q.ow_int != 16'h0000 && !st_q.shut) begin
      if (st_q.ms == MW'(MS_CYC - 1)) begin
        st_d.ms = '0;
        if (st_q.ow_cnt + 16'h0001 >= st_q.ow_int) begin
          st_d.ow_cnt  = '0;
          if (!st_q.ow_sink) st_d.ow_sink = 1'b1;
        end else begin
          st_d.ow_cnt = st_q.ow_cnt + 16'h0001;
        end
      end else begin
        st_d.ms = st_q.ms + MW'(1);
      end
    end else begin
      st_d.ms     = '0;
      st_d.ow_cnt = '0;
    end

    // --------------------------------------------------------------
    // Hardware set wins over a software clear
    // --------------------------------------------------------------
    if (manual && |prot_block_i) st_d.flags[FL_PROT] = 1'b1;
    if (st_q.fcfg.sense_en && !st_q.fuse_drv && st_q.fs2) begin
      st_d.pf            = 1'b1;
      st_d.flags[FL_SEC] = 1'b1;
    end
    if (pf_event_i) st_d.pf = 1'b1;
    if (st_d.pf) st_d.flags[FL_PF] = 1'b1;

    // Fuse drive decided from registered state and the unregistered pack or stack voltage input
    st_d.fuse_drv = fuse_ok && !st_q.shut;
    // Any remaining cause keeps the switch off
    st_d.fet_en = st_q.shut ? 4'h0
                  : ~(pin_blk | st_q.host_off | prot_blk);

    // --------------------------------------------------------------
    // Multifunction pins
    // --------------------------------------------------------------
    for (int i = 0; i < 3; i++) begin
      st_d.mf_ext[i] = st_q.pcfg.ext_sup[i];
      st_d.mf_pd[i]  = st_q.pcfg.pull_en[i] && !st_q.pcfg.pull_up[i];
      st_d.mf_pu[i]  = st_q.pcfg.pull_en[i] && st_q.pcfg.pull_up[i];
      st_d.mf_out[i] = st_q.pcfg.gpo_en[i] && st_q.pcfg.gpo_val[i];
      st_d.mf_oe[i]  = st_q.pcfg.gpo_en[i];
    end
    if (st_q.ctrl.link_sw) begin
      st_d.mf_out[0] = 1'b0;
      st_d.mf_oe[0]  = link_tx_low_i;
    end else if (!st_q.pcfg.gpo_en[0]) begin
      case (st_q.pcfg.alert_style)
        ALR_HIGH: begin
          st_d.mf_out[0] = alarm;
          st_d.mf_oe[0]  = 1'b1;
        end
        ALR_INV_LOW: begin
          st_d.mf_out[0] = !alarm;
          st_d.mf_oe[0]  = 1'b1;
        end
        default: begin
          st_d.mf_out[0] = 1'b0;
          st_d.mf_oe[0]  = alarm;
        end
      endcase
    end
    if (st_q.shut) st_d.mf_oe = 3'h0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q        <= '0;
      st_q.ctrl   <= CTRL_RST;
      st_q.pwr_on <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o     = st_q.rdata;
  assign mf_out_o        = st_q.mf_out;
  assign mf_oe_o         = st_q.mf_oe;
  assign mf_ext_supply_o = st_q.mf_ext;
  assign mf_pulldown_o   = st_q.mf_pd;
  assign mf_pullup_o     = st_q.mf_pu;
  assign fuse_o          = st_q.fuse_drv;
  assign fuse_oe_o       = st_q.fuse_drv;
  assign fet_en_o        = st_q.fet_en;
  assign link_sel_o      = st_q.ctrl.link_sw;
  assign comm_rst_o      = st_q.comm_rst;
  assign osc_en_o        = st_q.pwr_on;
  assign core_reg_en_o   = st_q.pwr_on;
  assign prereg_en_o     = st_q.pwr_on;
  assign ext_reg_en_o    = st_q.pwr_on;
  assign ow_sink_o       = st_q.ow_sink;
  assign ow_fault_o      = st_q.ow_fault;
  assign pf_o            = st_q.pf;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_manual_alert;
    manual && (prot_block_i != 4'h0);
  endsequence

  sequence s_pin_held;
    st_q.rs2 && !st_q.shut;
  endsequence

  AST_MANUAL_FLAG: assert property (s_manual_alert |=> st_q.flags[FL_PROT])
    else $error("manual alert did not set flag");
  AST_PIN_COMM_RST: assert property (s_pin_held |=> st_q.comm_rst)
    else $error("pin reset did not reset comms");
  AST_PIN_KEEPS_FET: assert property (s_pin_held ##1 st_q.rs2 |-> $stable(st_q.host_off))
    else $error("pin reset changed host switch state");
  AST_SHUT_OFF: assert property (st_q.shut |=> st_q.fet_en == 4'h0 && !st_q.pwr_on)
    else $error("shutdown left switches or power on");
  AST_CHG_PIN: assert property (chg_off |=> !st_q.fet_en[SW_CHG] && !st_q.fet_en[SW_PRECHARGE_SWITCH])
    else $error("charge pin did not disable charge pair");
  AST_BOTH_OFF: assert property (st_q.ctrl.combined && dsg_off |=> st_q.fet_en == 4'h0)
    else $error("combined pin left a switch on");
  AST_REENABLE: assert property (!st_q.shut && pin_blk == 4'h0 && st_q.host_off == 4'h0
                                 && prot_blk == 4'h0 |=> st_q.fet_en == 4'hF)
    else $error("switch not re-enabled without cause");
  AST_LINK_OD: assert property ($past(st_q.ctrl.link_sw) |-> !st_q.mf_out[0])
    else $error("link pin drove high");
  AST_ALARM_HIGH: assert property (!st_q.ctrl.link_sw && !st_q.pcfg.gpo_en[0] && !st_q.shut
                                   && st_q.pcfg.alert_style == ALR_HIGH
                                   |=> st_q.mf_oe[0] && st_q.mf_out[0] == $past(alarm))
    else $error("alarm output not masked OR");
  AST_FUSE_THR: assert property (st_q.fuse_drv |-> $past(fuse_ok))
    else $error("fuse driven below threshold");
  AST_OW_LEN: assert property (st_q.ow_sink && st_q.meas == TW'(MEAS_CYC - 1)
                               |=> !st_q.ow_sink)
    else $error("open-wire sink overran measurement time");
  AST_OW_ABOVE: assert property (st_q.ow_fault[0] |-> st_q.ow_fault[1])
    else $error("open cell fault missed cell above");

endmodule : pack_protector_pin_control

`default_nettype wire

// >>> test/host_pin_model.sv
// Host-side pin model: reset pin, switch-off pins, secondary protector, pin wires
`timescale 1ns/1ps
`default_nettype none

module host_pin_model (
  input  wire logic       shut_req_i,
  input  wire logic       chg_off_req_i,
  input  wire logic       dsg_off_req_i,
  input  wire logic       trip_i,
  input  wire logic [2:0] mf_out_i,
  input  wire logic [2:0] mf_oe_i,
  input  wire logic       fuse_drv_i,
  input  wire logic       fuse_oe_i,
  output logic            rst_shut_o,
  output logic      [2:0] mf_in_o,
  output logic            fuse_o
);
  // Reset pin sits low unless a reset or shutdown is wanted
  assign rst_shut_o = shut_req_i;
  // Alarm wire has a pull-up; the other pins follow the host unless the device drives them
  assign mf_in_o[0] = mf_oe_i[0] ? mf_out_i[0] : 1'b1;
  assign mf_in_o[1] = mf_oe_i[1] ? mf_out_i[1] : chg_off_req_i;
  assign mf_in_o[2] = mf_oe_i[2] ? mf_out_i[2] : dsg_off_req_i;
  // Fuse gate has a pulldown; the secondary protector may pull it high
  assign fuse_o = (fuse_oe_i & fuse_drv_i) | trip_i;
endmodule : host_pin_model

`default_nettype wire

// >>> test/tb_pack_protector_pin_control.sv
// Testbench for the pack protector pin control block
`timescale 1ns/1ps
`default_nettype none

module tb_pack_protector_pin_control;
  import pack_protector_pkg::*;
  logic sys_clk_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0, link_tx_low_i = 0, pf_event_i = 0;
  logic shut = 0, c_off = 0, d_off = 0, trip = 0, rst_shut, fuse_in, fuse_out, fuse_oe, pf;
  logic link_sel, comm_rst, osc, core, prereg, ext, sink;
  logic [7:0]  reg_addr_i = 8'h00, alarm_event_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, rdata;
  logic [2:0]  mf_in, mf_out, mf_oe, ext_sup, pdn, pup;
  logic [3:0]  prot_block_i = 4'h0, fet_en;
  logic [15:0] stack_mv_i = 16'h0, pack_mv_i = 16'h0;
  logic [4:0]  cell_low_i = 5'h00, cell_pf_i = 5'h00, ow_fault;
  int error_cnt = 0, num_checks = 0, n;

  initial forever #5 sys_clk_i = ~sys_clk_i;

  pack_protector_pin_control #(.CELLS(5), .HOLD_CYC(20), .MS_CYC(4), .MEAS_CYC(3))
  i_pack_protector_pin_control (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
    .rst_shut_i(rst_shut), .mf_in_i(mf_in), .mf_out_o(mf_out), .mf_oe_o(mf_oe),
    .mf_ext_supply_o(ext_sup), .mf_pulldown_o(pdn), .mf_pullup_o(pup),
    .link_tx_low_i(link_tx_low_i), .fuse_i(fuse_in), .fuse_o(fuse_out), .fuse_oe_o(fuse_oe),
    .prot_block_i(prot_block_i), .pf_event_i(pf_event_i), .alarm_event_i(alarm_event_i),
    .stack_mv_i(stack_mv_i), .pack_mv_i(pack_mv_i), .cell_low_i(cell_low_i),
    .cell_pf_i(cell_pf_i), .fet_en_o(fet_en), .link_sel_o(link_sel), .comm_rst_o(comm_rst),
    .osc_en_o(osc), .core_reg_en_o(core), .prereg_en_o(prereg), .ext_reg_en_o(ext),
    .ow_sink_o(sink), .ow_fault_o(ow_fault), .pf_o(pf));

  host_pin_model i_host_pin_model (.shut_req_i(shut), .chg_off_req_i(c_off),
    .dsg_off_req_i(d_off), .trip_i(trip), .mf_out_i(mf_out), .mf_oe_i(mf_oe),
    .fuse_drv_i(fuse_out), .fuse_oe_i(fuse_oe), .rst_shut_o(rst_shut), .mf_in_o(mf_in),
    .fuse_o(fuse_in));

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk_i);
    reg_addr_i <= a; reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask : rd

  task automatic do_reset;
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    tick(3);
    srst_i <= 1'b0;
    tick(2);
  endtask : do_reset

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // Guards against a hang anywhere in the sequence
  initial begin
    #300000;
    error_cnt++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  logic [1:0] act_t [3] = '{2'b01, 2'b11, 2'b01};
  logic [1:0] idl_t [3] = '{2'b00, 2'b01, 2'b11};
  initial begin
    do_reset();
    rd(REG_CTRL, 32'h3, "ctrl");
    chk("link", 0, link_sel);
    rd(8'h40, 32'h0, "unmapped");
    chk("fet", 32'hF, fet_en);
    // Host off on charge, then the charge pin; release leaves the host block standing
    wr(REG_HOSTFET, 32'h1);
    c_off <= 1'b1;
    tick(5);
    chk("fet chg pin", 32'hC, fet_en);
    c_off <= 1'b0;
    tick(5);
    chk("fet pin off", 32'hE, fet_en);
    wr(REG_HOSTFET, 32'h0);
    tick(3);
    chk("fet clear", 32'hF, fet_en);
    wr(REG_CTRL, 32'h7);
    d_off <= 1'b1;
    tick(5);
    chk("fet both", 32'h0, fet_en);
    d_off <= 1'b0;
    // Manual mode only flags; standalone turns off and recovers
    wr(REG_CTRL, 32'h23);
    prot_block_i <= 4'h4;
    tick(4);
    chk("fet manual", 32'hF, fet_en);
    rd(REG_FLAGS, 32'h1, "flags");
    wr(REG_CTRL, 32'h3);
    tick(3);
    chk("fet auto", 32'hB, fet_en);
    prot_block_i <= 4'h0;
    tick(3);
    chk("fet recover", 32'hF, fet_en);
    // Alarm styles, active and idle, one masked source
    wr(REG_MASK, 32'h100);
    for (int s = 0; s < 3; s++) begin
      wr(REG_PINCFG, 32'(s) << 15);
      alarm_event_i <= 8'h01;
      tick(4);
      chk("alarm act", {30'h0, act_t[s]}, {mf_out[0] & mf_oe[0], mf_oe[0]});
      alarm_event_i <= 8'h02;
      tick(4);
      chk("alarm idle", {30'h0, idl_t[s]}, {mf_out[0] & mf_oe[0], mf_oe[0]});
    end
    wr(REG_CTRL, 32'hB);
    link_tx_low_i <= 1'b1;
    tick(3);
    chk("link pin", 32'h5, {link_sel, mf_out[0], mf_oe[0]});
    link_tx_low_i <= 1'b0;
    tick(3);
    chk("link idle", 32'h4, {link_sel, mf_out[0], mf_oe[0]});
    // General-purpose output on pin 2, pulls on pins 0 and 1
    wr(REG_CTRL, 32'h3);
    wr(REG_PINCFG, 32'h2724);
    tick(2);
    chk("gpo", 32'h3, {mf_out[2], mf_oe[2]});
    chk("supply", 32'h4, ext_sup);
    chk("pulls", 32'h11, {pup, pdn});
    wr(REG_PINCFG, 32'h0);
    // Open wire, interval 4 cycles, sink 3 cycles
    cell_low_i <= 5'h04;
    wr(REG_OWINT, 32'h1);
    tick(6);
    n = 0;
    repeat (40) begin
      tick(1);
      n += int'(sink);
    end
    chk("sink cycles", 32'd30, n);
    chk("ow fault", 32'h0C, ow_fault);
    wr(REG_OWINT, 32'h0);
    cell_low_i <= 5'h00;
    // Reset pin keeps switch state, then shuts down
    wr(REG_HOSTFET, 32'h1);
    shut <= 1'b1;
    n = 0;
    while (comm_rst !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    chk("comm rst", 32'h1, comm_rst);
    chk("fet kept", 32'hE, fet_en);
    rd(REG_CTRL, 32'h0, "ctrl in reset");
    tick(30);
    chk("shutdown", 32'h0, {fet_en, osc, core, prereg, ext});
    shut <= 1'b0;
    do_reset();
    // Fuse sensing, then blow decision on pack then stack
    wr(REG_FUSE, 32'h20000);
    trip <= 1'b1;
    tick(5);
    chk("pf sensed", 32'h1, pf);
    rd(REG_FLAGS, 32'h6, "flags fuse");
    trip <= 1'b0;
    stack_mv_i <= 16'h00C8;
    pack_mv_i <= 16'h0032;
    wr(REG_FUSE, 32'h50064);
    tick(3);
    chk("fuse pack", 32'h0, {fuse_out, fuse_oe});
    wr(REG_FUSE, 32'h40064);
    tick(3);
    chk("fuse stack", 32'h3, {fuse_out, fuse_oe});
    chk("fet pf", 32'h0, fet_en);
    complete_run();
  end
endmodule : tb_pack_protector_pin_control

`default_nettype wire
